// *** pkg/ddr_pin_consts.svh ***
// timing and field constants for the memory pin interface
`ifndef DDR_PIN_CONSTS_SVH
`define DDR_PIN_CONSTS_SVH
`define CLK_PERIOD_PS       5000
`define SYNC_STAGES         2
`define MR_ODT_EN_BIT       0
`define MR_TDQS_EN_BIT      1
`define MR_RD_LAT_DEF       4'h0004
`define MR_RESET_VAL        16'h0001
`define BURST_BEATS         8
`define BEAT_CNT_W          4
`define CMD_MRS             4'h0
`define CMD_REF             4'h1
`define CMD_PRE             4'h2
`define CMD_ACT             4'h3
`define CMD_WR              4'h4
`define CMD_RD              4'h5
`define CMD_ZQ              4'h6
`define CMD_NOP             4'h7
`endif

// *** pkg/ddr_pin_pkg.sv ***
// types shared by the memory pin interface files
package ddr_pin_pkg;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_LOAD_MODE,
		OP_WRITE,
		OP_READ,
		OP_OTHER
	} cmd_op_e;
	typedef struct packed {
		logic cs_n;  // chip select, low active
		logic ras_n; // row strobe
		logic cas_n; // column strobe
		logic we_n;  // write enable
	} cmd_pins_s;
	typedef struct packed {
		logic [7:0] dq;  // data bits out
		logic [7:0] dq_oe; // data drive enables
		logic       dqs; // strobe true
		logic       dqs_n; // strobe complement
		logic       dqs_oe; // strobe drive enable
	} rd_drive_s;
endpackage : ddr_pin_pkg

// *** hw/pin_sync.sv ***
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             I_CLK, // core clock
	input  wire logic             I_RST, // async reset, high
	input  wire logic [WIDTH-1:0] i_d,   // raw pin levels
	output logic      [WIDTH-1:0] o_q    // synchronised levels
);
	logic [WIDTH-1:0] meta_reg; // first stage, read only by second
	// first stage only feeds the second to keep metastability contained
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			meta_reg <= '0;
			o_q      <= '0;
		end else begin
			meta_reg <= i_d;
			o_q      <= meta_reg;
		end
	end
endmodule : pin_sync

// *** hw/cmd_decode.sv ***
// command decoder from sampled command pins
`timescale 1ns/1ps
module cmd_decode
	import ddr_pin_pkg::*;
(
	input  ddr_pin_pkg::cmd_pins_s i_pins, // pins at sample point
	output ddr_pin_pkg::cmd_op_e   o_op    // decoded operation
);
	// chip select is part of the code; high masks everything
	always_comb begin
		o_op = OP_NONE;
		if (!i_pins.cs_n) begin
			unique case ({i_pins.ras_n, i_pins.cas_n, i_pins.we_n})
				3'b000:  o_op = OP_LOAD_MODE;
				3'b100:  o_op = OP_WRITE;
				3'b101:  o_op = OP_READ;
				3'b111:  o_op = OP_NONE; // no operation
				default: o_op = OP_OTHER;
			endcase
		end
	end
endmodule : cmd_decode

// *** hw/ddr_pin_if.sv ***
`timescale 1ns/1ps
`include "ddr_pin_consts.svh"
module ddr_pin_if #(
	parameter bit WIDE_X8 = 1'b1, // 1: x8 part, 0: x4 part
	parameter int DEPTH   = 16    // stored beats
) (
	input  wire logic                  I_CLK,       // core clock, 200 MHz
	input  wire logic                  I_RST,       // core reset, high
	input  wire logic                  I_RESET_N,   // device reset pin
	input  wire logic                  I_CK,        // memory clock pin
	input  ddr_pin_pkg::cmd_pins_s     I_CMD,       // command pins
	input  wire logic [15:0]           I_MODE_OP,   // mode load opcode
	input  wire logic                  I_ODT,       // termination pin
	input  wire logic                  I_DM,        // write mask pin
	input  wire logic [7:0]            I_DQ,        // data pins in
	input  wire logic                  I_DQS,       // strobe pin in
	input  wire logic [3:0]            I_ADDR,      // beat address
	output ddr_pin_pkg::rd_drive_s     O_RD,        // read pin drive
	output logic      [7:0]            O_TERM_DQ,   // dq termination on
	output logic                       O_TERM_DQS,  // strobe termination
	output logic                       O_TERM_DM,   // mask ball term
	output logic                       O_TERM_TDQS, // tdqs pair term
	output logic                       O_MASK_EN,   // masking active
	output logic      [2:0]            O_LAST_OP    // last decoded op
);
	import ddr_pin_pkg::*;

	localparam int DW = WIDE_X8 ? 8 : 4;
	localparam int AW = $clog2(DEPTH);

	// combined reset: core reset or device pin low, both asynchronous
	logic rst_any;
	// the pin is not synchronised here: it must act with no clock running
	assign rst_any = I_RST | ~I_RESET_N;

	// every pin but the reset pin is synchronised before the core clock looks at it
	logic [15:0] sync_in;
	logic [15:0] sync_out;
	assign sync_in = {I_CK, I_CMD, I_ODT, I_DM, I_DQS, I_DQ[7:0]};
	pin_sync #(.WIDTH(16)) u_sync (
		.I_CLK (I_CLK),
		.I_RST (rst_any),
		.i_d   (sync_in),
		.o_q   (sync_out)
	);

	logic      ck_s;       // clock pin level
	cmd_pins_s cmd_s;      // command pins
	logic      odt_s;      // termination pin
	logic      dm_s;       // mask pin
	logic      dqs_s;      // strobe pin
	logic [7:0] dq_s;      // data pins
	assign ck_s  = sync_out[15];
	assign cmd_s = sync_out[14:11];
	assign odt_s = sync_out[10];
	assign dm_s  = sync_out[9];
	assign dqs_s = sync_out[8];
	assign dq_s  = sync_out[7:0];

	// opcode and start address come from pins as well; they pass the
	// same two stages as the command, so both line up with the crossing
	// on which the command is taken
	// limitation: the far side must hold them over the whole crossing
	logic [19:0] side_in;   // opcode and address pins
	logic [19:0] side_out;  // synchronised copy
	logic [15:0] mode_op_s; // opcode as seen by the core
	logic [3:0]  addr_s;    // start address as seen by the core
	assign side_in = {I_MODE_OP, I_ADDR};
	pin_sync #(.WIDTH(20)) u_sync_side (
		.I_CLK (I_CLK),
		.I_RST (rst_any),
		.i_d   (side_in),
		.o_q   (side_out)
	);
	assign mode_op_s = side_out[19:4];
	assign addr_s    = side_out[3:0];

	// edge finder on the memory clock
	logic ck_d_reg;  // last clock level
	logic ck_rise;   // rising crossing seen
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) ck_d_reg <= 1'b0;
		else         ck_d_reg <= ck_s;
	end
	assign ck_rise = ck_s & ~ck_d_reg;

	// strobe edge finder for write capture
	logic dqs_d_reg; // last strobe level
	logic dqs_edge;  // any strobe transition
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) dqs_d_reg <= 1'b0;
		else         dqs_d_reg <= dqs_s;
	end
	assign dqs_edge = dqs_s ^ dqs_d_reg;

	// decoder looks only at pins caught at a rising crossing
	cmd_op_e op;
	cmd_decode u_dec (
		.i_pins (cmd_s),
		.o_op   (op)
	);
	cmd_op_e op_taken; // masked unless sampled on the crossing
	assign op_taken = ck_rise ? op : OP_NONE;

	logic [2:0] last_op_reg; // reported last command
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) last_op_reg <= 3'h0;
		else if (op_taken != OP_NONE) last_op_reg <= 3'(op_taken);
	end
	assign O_LAST_OP = last_op_reg;

	// mode bits, loaded by the mode load command
	logic [15:0] mode_reg; // bit0 odt enable, bit1 tdqs enable
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) mode_reg <= `MR_RESET_VAL;
		else if (op_taken == OP_LOAD_MODE) mode_reg <= mode_op_s;
	end
	logic odt_enabled; // termination allowed by mode
	logic tdqs_on;     // termination strobe mode, x8 only
	assign odt_enabled = mode_reg[`MR_ODT_EN_BIT];
	assign tdqs_on = WIDE_X8 && mode_reg[`MR_TDQS_EN_BIT];

	// termination level registered at the crossing
	logic term_reg; // termination currently applied
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) term_reg <= 1'b0;
		else if (!odt_enabled) term_reg <= 1'b0;
		else if (ck_rise) term_reg <= odt_s;
	end
	// only data, strobes and mask terminate; unused x4 balls never do
	always_comb begin
		O_TERM_DQ   = '0;
		O_TERM_DQ[DW-1:0] = {DW{term_reg}};
		O_TERM_DQS  = term_reg;
		O_TERM_DM   = term_reg & ~tdqs_on;
		O_TERM_TDQS = term_reg & tdqs_on;
	end
	assign O_MASK_EN = ~tdqs_on;

	// burst state for reads and writes
	typedef enum {ST_IDLE, ST_WRITE, ST_READ} burst_e;
	burst_e state_reg;
	logic [`BEAT_CNT_W-1:0] beat_reg;  // beats done in burst
	logic [AW-1:0]          ptr_reg;   // current beat address
	logic                   done;      // burst finished
	assign done = (beat_reg == `BEAT_CNT_W'(`BURST_BEATS - 1));

	// sequencer: commands only start from idle
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) begin
			state_reg <= ST_IDLE;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (op_taken == OP_WRITE) state_reg <= ST_WRITE;
					else if (op_taken == OP_READ) state_reg <= ST_READ;
				end
				ST_WRITE: begin
					if (dqs_edge && done) state_reg <= ST_IDLE;
				end
				ST_READ: begin
					if (ck_rise && done) state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// beat counter and address; write beats follow strobe edges
	logic beat_step; // one beat passes this cycle
	assign beat_step = (state_reg == ST_WRITE && dqs_edge) ||
	                   (state_reg == ST_READ && ck_rise);
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) begin
			beat_reg <= '0;
			ptr_reg  <= '0;
		end else if (state_reg == ST_IDLE) begin
			beat_reg <= '0;
			if (op_taken == OP_WRITE || op_taken == OP_READ)
				ptr_reg <= AW'(addr_s);
		end else if (beat_step) begin
			beat_reg <= beat_reg + 1'b1;
			ptr_reg  <= ptr_reg + 1'b1;
		end
	end

	// storage array; a masked beat keeps the old content
	logic [7:0] mem [DEPTH]; // beat storage
	// strobe edges sit mid eye, so data is steady when captured
	always_ff @(posedge I_CLK) begin
		if (state_reg == ST_WRITE && dqs_edge) begin
			if (!(dm_s && !tdqs_on))
				mem[ptr_reg] <= dq_s;
		end
	end

	// read drive: data and strobe change on the same crossing
	logic [7:0] rd_dq_reg;  // read data out
	logic       rd_dqs_reg; // strobe toggles with each beat
	logic       rd_oe_reg;  // drive enable
	always_ff @(posedge I_CLK or posedge rst_any) begin
		if (rst_any) begin
			rd_dq_reg  <= '0;
			rd_dqs_reg <= 1'b0;
			rd_oe_reg  <= 1'b0;
		end else if (state_reg == ST_READ && ck_rise) begin
			rd_dq_reg  <= mem[ptr_reg];
			rd_dqs_reg <= ~rd_dqs_reg;
			rd_oe_reg  <= 1'b1;
		end else if (state_reg != ST_READ && ck_rise) begin
			// release only at a crossing, so the last beat stands a
			// full memory clock like every other beat
			rd_oe_reg  <= 1'b0;
			rd_dqs_reg <= 1'b0;
		end
	end
	// upper lane is never driven on x4 parts
	always_comb begin
		O_RD        = '0;
		O_RD.dq[DW-1:0]    = rd_dq_reg[DW-1:0];
		O_RD.dq_oe[DW-1:0] = {DW{rd_oe_reg}};
		O_RD.dqs    = rd_dqs_reg;
		O_RD.dqs_n  = ~rd_dqs_reg & rd_oe_reg;
		O_RD.dqs_oe = rd_oe_reg;
	end
endmodule : ddr_pin_if

// *** dv/ddr_pin_if_assertions.sv ***
// concurrent checks on the memory pin interface ports
`timescale 1ns/1ps
module ddr_pin_if_assertions
	import ddr_pin_pkg::*;
#(
	parameter bit WIDE_X8 = 1'b1, // part width
	parameter int DEPTH   = 16    // stored beats
) (
	input wire logic              I_CLK,       // core clock
	input wire logic              I_RST,       // core reset
	input wire logic              I_RESET_N,   // device reset pin
	input ddr_pin_pkg::cmd_pins_s I_CMD,       // command pins
	input ddr_pin_pkg::rd_drive_s O_RD,        // read drive
	input wire logic [7:0]        O_TERM_DQ,   // dq termination
	input wire logic              O_TERM_DQS,  // strobe termination
	input wire logic              O_TERM_DM,   // mask termination
	input wire logic              O_TERM_TDQS, // tdqs termination
	input wire logic              O_MASK_EN,   // masking active
	input wire logic [2:0]        O_LAST_OP    // last op
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST || !I_RESET_N);
	// six idle samples cover the whole sync and decode pipeline
	sequence idle_sel;
		I_CMD.cs_n [*6];
	endsequence
	reset_clear_a: assert property (disable iff (1'b0)
		I_RST |-> O_LAST_OP == 3'h0 && O_MASK_EN && O_RD.dq_oe == 8'h00)
		else $error("core reset left outputs set");
	pin_reset_a: assert property (disable iff (1'b0)
		!I_RESET_N |-> O_LAST_OP == 3'h0 && O_MASK_EN && !O_TERM_DQS)
		else $error("reset pin left outputs set");
	sel_mask_a: assert property (idle_sel |=> $stable(O_LAST_OP))
		else $error("op changed while deselected");
	dqs_pair_a: assert property (O_RD.dqs_oe |-> O_RD.dqs_n == !O_RD.dqs)
		else $error("strobe pair not complementary");
	data_strobe_a: assert property (O_RD.dq_oe != 8'h00 |-> O_RD.dqs_oe)
		else $error("read data without strobe");
	term_set_a: assert property (O_TERM_DQS |->
		O_TERM_DQ[3:0] == 4'hf && (O_TERM_DM || O_TERM_TDQS))
		else $error("termination group split");
	tdqs_excl_a: assert property (O_TERM_TDQS |-> !O_MASK_EN)
		else $error("mask active in tdqs mode");
	x4_width_a: assert property (!WIDE_X8 |-> O_TERM_DQ[7:4] == 4'h0 &&
		O_RD.dq_oe[7:4] == 4'h0 && O_MASK_EN && !O_TERM_TDQS)
		else $error("x4 part used shared balls");
endmodule : ddr_pin_if_assertions
bind ddr_pin_if ddr_pin_if_assertions #(.WIDE_X8(WIDE_X8), .DEPTH(DEPTH)) chk (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_RESET_N(I_RESET_N), .I_CMD(I_CMD),
	.O_RD(O_RD), .O_TERM_DQ(O_TERM_DQ), .O_TERM_DQS(O_TERM_DQS),
	.O_TERM_DM(O_TERM_DM), .O_TERM_TDQS(O_TERM_TDQS),
	.O_MASK_EN(O_MASK_EN), .O_LAST_OP(O_LAST_OP));

// *** dv/ddr_ctrl_model.sv ***
// controller-side model: memory clock, commands and write bursts
`timescale 1ns/1ps
module ddr_ctrl_model
	import ddr_pin_pkg::*;
(
	output logic       o_ck   = 1'b0,     // free memory clock
	output cmd_pins_s  o_cmd  = 4'hf,     // deselected at rest
	output logic [15:0] o_mode = 16'h0001, // mode opcode
	output logic [3:0] o_addr = 4'h0,     // beat address
	output logic       o_dm   = 1'b0,     // write mask
	output logic [7:0] o_dq   = 8'h00,    // write data
	output logic       o_dqs  = 1'b0      // write strobe
);
	// offset keeps memory clock edges off core clock edges
	initial begin
		#1;
		forever #62.5 o_ck = ~o_ck;
	end
	// command held over one rising edge, then deselect
	task issue(input logic [3:0] c, input logic [15:0] op, input logic [3:0] a);
		@(negedge o_ck);
		o_cmd = c;
		o_mode = op;
		o_addr = a;
		@(negedge o_ck);
		o_cmd = 4'hf;
		o_mode = ~op;
	endtask : issue
	// strobe edge sits mid data eye; data inverted after release
	task wr_burst(input logic [63:0] d, input logic [7:0] m);
		for (int i = 0; i < 8; i++) begin
			o_dq = d[8*i+:8];
			o_dm = m[i];
			#31;
			o_dqs = ~o_dqs;
			#31;
		end
		o_dq = ~o_dq;
	endtask : wr_burst
endmodule : ddr_ctrl_model

// *** dv/tb_ddr3_sdram_pin_interface.sv ***
// self-checking bench for the memory pin interface
`timescale 1ns/1ps
module tb_ddr3_sdram_pin_interface;
	import ddr_pin_pkg::*;
	logic clk = 1'b0, rst = 1'b1, rst_n = 1'b1, odt = 1'b0;
	logic ck, dm, dqs, tdqs_s, tdm, ttdqs, mask_en;
	logic [7:0] dq, tdq;
	logic [3:0] addr;
	logic [15:0] mode;
	logic [2:0] last_op;
	cmd_pins_s cmd;
	rd_drive_s rd;
	int fail_count = 0, comparisons = 0;
	ddr_ctrl_model ctrl (.o_ck(ck), .o_cmd(cmd), .o_mode(mode),
		.o_addr(addr), .o_dm(dm), .o_dq(dq), .o_dqs(dqs));
	ddr_pin_if #(.WIDE_X8(1'b1), .DEPTH(16)) dut (.I_CLK(clk), .I_RST(rst),
		.I_RESET_N(rst_n), .I_CK(ck), .I_CMD(cmd), .I_MODE_OP(mode),
		.I_ODT(odt), .I_DM(dm), .I_DQ(dq), .I_DQS(dqs), .I_ADDR(addr),
		.O_RD(rd), .O_TERM_DQ(tdq), .O_TERM_DQS(tdqs_s), .O_TERM_DM(tdm),
		.O_TERM_TDQS(ttdqs), .O_MASK_EN(mask_en), .O_LAST_OP(last_op));
	initial forever #2.5 clk = ~clk;
	task chk(input string n, input logic [63:0] e, input logic [63:0] s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task end_sim;
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	// two memory clocks plus sync margin for termination to follow
	task settle;
		repeat (2) @(posedge ck);
		repeat (6) @(posedge clk);
	endtask : settle
	// the four other-class codes and mode load, then nop and deselected read leave op alone
	task t_decode;
		logic [2:0] pins [5] = '{3'b011, 3'b010, 3'b001, 3'b110, 3'b000};
		for (int i = 0; i < 5; i++) begin
			ctrl.issue({1'b0, pins[i]}, 16'h0001, 4'h0);
			chk("op", (i < 4) ? OP_OTHER : OP_LOAD_MODE, last_op);
		end
		ctrl.issue(4'b0111, 16'h0001, 4'h0);
		chk("nop", OP_LOAD_MODE, last_op);
		ctrl.issue(4'b1101, 16'h0001, 4'h0);
		chk("desel", OP_LOAD_MODE, last_op);
	endtask : t_decode
	// full write, masked overwrite, read back with strobe toggling
	task t_write_read;
		logic [63:0] a = 64'h1122_3344_5566_7788, b = 64'h99aa_bbcc_ddee_f00f;
		logic [7:0] m = 8'h24;
		logic p;
		ctrl.issue(4'b0100, 16'h0001, 4'h0);
		ctrl.wr_burst(a, 8'h00);
		settle;
		ctrl.issue(4'b0100, 16'h0001, 4'h0);
		ctrl.wr_burst(b, m);
		settle;
		chk("wr op", OP_WRITE, last_op);
		ctrl.issue(4'b0101, 16'h0001, 4'h0);
		for (int w = 0; w < 100 && rd.dq_oe !== 8'hff; w++) @(posedge clk);
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 8; i++) begin
			chk("oe", 8'hff, rd.dq_oe);
			chk("rd", m[i] ? a[8*i+:8] : b[8*i+:8], rd.dq);
			if (i > 0) chk("dqs", !p, rd.dqs);
			p = rd.dqs;
			repeat (25) @(posedge clk);
		end
		chk("oe off", 8'h00, rd.dq_oe);
		chk("rd op", OP_READ, last_op);
	endtask : t_write_read
	// termination on/off, disabled by mode, then tdqs mode
	task t_odt;
		@(posedge clk) odt <= 1'b1;
		settle;
		chk("term", 11'h7fe, {tdq, tdqs_s, tdm, ttdqs});
		@(posedge clk) odt <= 1'b0;
		settle;
		chk("term off", 8'h00, tdq);
		ctrl.issue(4'b0000, 16'h0000, 4'h0);
		@(posedge clk) odt <= 1'b1;
		settle;
		chk("odt off", 8'h00, tdq);
		ctrl.issue(4'b0000, 16'h0003, 4'h0);
		settle;
		chk("tdqs", 2'b10, {ttdqs, mask_en});
	endtask : t_odt
	// reset pin acts between core clock edges
	task t_pin_reset;
		@(posedge clk) rst_n <= 1'b0;
		#1;
		chk("pin rst", {OP_NONE, 1'b1}, {last_op, mask_en});
		@(posedge clk) rst_n <= 1'b1;
	endtask : t_pin_reset
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("reset", {OP_NONE, 1'b1}, {last_op, mask_en});
		t_decode;
		t_write_read;
		t_odt;
		t_pin_reset;
		end_sim;
	end
	// whole run is near 1,200 core cycles
	initial begin
		#100000;
		fail_count++;
		end_sim;
	end
endmodule : tb_ddr3_sdram_pin_interface
